/* alarm_calendar_clock.sv */
// serial alarm calendar clock: timekeeping, alarms, user storage and serial link
`timescale 1ns/1ps
// Summary of operation
// - count seconds to year with leap correction valid through 2099
// - date rolls to the first after each month's last day, leap february too
// - hours run in 24-hour or 12-hour with pm flag, per mode bit
// - 96 bytes of user storage readable and writable by the host
// - strap low selects 3-wire signalling, strap high selects spi
// - first irq is active low, from alarm 0 alone or either alarm
// - second irq is active low and follows alarm 1 only, and only while routing is 1
// - irq stays low while a flag routed to it and that flag's enable are both set
// - irq pins are open drain, only ever pulled low
// - timekeeping and alarms keep running without primary supply
// - supply loss output low when primary is below secondary or battery
// - timebase is a 32.768 khz crystal or external oscillator on crystal in
// - writes hit clock space at 80h-9Fh and storage at A0h-FFh
// - reads hit clock space at 00h-1Fh, storage at 20h-7Fh; bit 7 is direction
// - bits fixed at zero always read zero
// - reserved clock registers 12h-1Fh ignore writes and read zero
// - time, calendar and alarm values are bcd
// - a transfer moves one byte or a burst of successive bytes
// - two independent alarms matching seconds, minutes, hours and day
// - routing 1: alarm 0 to first irq, alarm 1 to second; 0: both to first
// - write protect set blocks every write except to the protect bit itself until cleared
// - oscillator stop 0 runs timekeeping, 1 halts it
// - bit 7 of each alarm register masks that field from the match
module alarm_calendar_clock #(
  parameter int TICKS_PER_SEC = rtc_pkg::XTAL_HZ
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic ce,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  input wire logic link_style_select,
  input wire logic crystal_in,
  input wire logic primary_below_secondary,
  input wire logic primary_below_battery,
  output logic alarm_irq_a_n,
  output logic alarm_irq_a_oe_n,
  output logic alarm_irq_b_n,
  output logic alarm_irq_b_oe_n,
  output logic supply_loss_n
);
  import rtc_pkg::*;

  // ******************************************
  // helpers
  // ******************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = v + 8'h01;
    end
  endfunction : bcd_inc

  // 2-digit year: 00 counts as leap, so 2000 and 2100-as-00 are ambiguous by design
  function automatic logic leap_year(input logic [7:0] yr);
    if (yr[4]) begin
      leap_year = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
    end else begin
      leap_year = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
    end
  endfunction : leap_year

  function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
    unique case (mon)
      8'h02: month_end = leap_year(yr) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
      default: month_end = 8'h31;
    endcase
  endfunction : month_end

  function automatic logic [8:0] hour_inc(input logic [7:0] h);
    logic [7:0] v;
    logic [7:0] s;
    logic carry;
    v = h;
    s = 8'h00;
    carry = 1'b0;
    if (h[B_H12]) begin
      if (h[4:0] == 5'h12) begin
        v[4:0] = 5'h01;
      end else if (h[4:0] == 5'h11) begin
        v[4:0] = 5'h12;
        v[B_PM] = ~h[B_PM];
        carry = h[B_PM];
      end else begin
        s = bcd_inc({3'h0, h[4:0]});
        v[4:0] = s[4:0];
      end
    end else if (h[5:0] == 6'h23) begin
      v[5:0] = 6'h00;
      carry = 1'b1;
    end else begin
      s = bcd_inc({2'h0, h[5:0]});
      v[5:0] = s[5:0];
    end
    hour_inc = {carry, v};
  endfunction : hour_inc

  // stage one only feeds stage two, so a metastable first flop never reaches logic
  function automatic logic settle(input logic [2:0] s, input logic f);
    if (s[1] == s[2]) begin
      settle = s[2];
    end else begin
      settle = f;
    end
  endfunction : settle

  function automatic logic in_bank(input logic [6:0] a, input logic [6:0] base);
    in_bank = (a >= base) && (a < base + 7'h4);
  endfunction : in_bank

  function automatic logic alarm_hit(input logic [NREG-1:0][7:0] v, input logic [6:0] base);
    alarm_hit = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (!v[base + 7'(i)][B_MASK] && v[base + 7'(i)][6:0] != v[i][6:0]) begin
        alarm_hit = 1'b0;
      end
    end
  endfunction : alarm_hit

  function automatic logic [7:0] write_mask(input logic [6:0] a);
    if (a == A_DAY) begin
      write_mask = M_DAY;
    end else if (a == A_DATE) begin
      write_mask = M_DATE;
    end else if (a == A_MONTH) begin
      write_mask = M_MONTH;
    end else if (a == A_YEAR) begin
      write_mask = M_YEAR;
    end else if (a < A_ALM0) begin
      write_mask = M_TIME;
    end else if (a == A_ALM0 + 7'h3 || a == A_ALM1 + 7'h3) begin
      write_mask = M_ALM_DAY;
    end else if (a < A_CTRL) begin
      write_mask = M_ALM;
    end else begin
      write_mask = M_CTRL;
    end
  endfunction : write_mask

  // burst stays inside its space: clock wraps to 00h, storage wraps to 20h
  function automatic logic [6:0] next_addr(input logic [6:0] a);
    if (a == A_CLK_TOP) begin
      next_addr = 7'h00;
    end else if (a == A_RAM_TOP) begin
      next_addr = A_RAM;
    end else begin
      next_addr = a + 7'h01;
    end
  endfunction : next_addr

  // ******************************************
  // state
  // ******************************************
  core_t r;
  core_t n;
  link_t lr;
  link_t ln;
  handoff_t hr;
  drive_t dr;
  logic [7:0] ram [RAM_BYTES];
  logic wr_ev;
  logic wp;
  logic [7:0] byte_in;
  logic byte_done;
  logic wr_fire;
  logic [7:0] rd_byte;
  logic [2:0] out_idx;
  logic wr_clock;
  logic wr_store;

  assign wp = r.regs[A_CTRL][B_WP];
  assign wr_ev = r.tg_s[1] ^ r.tg_s[2];
  // protect stops storage outright; clock space keeps the protect bit writable
  assign wr_clock = wr_ev && hr.addr < A_STAT;
  assign wr_store = wr_ev && hr.addr >= A_RAM && !wp;

  // ******************************************
  // core domain: timebase, calendar, alarms, writes
  // ******************************************
  always_comb begin
    logic [NREG-1:0][7:0] t;
    logic c;
    logic xt_rise;
    logic sec_tick;
    logic [8:0] hc;
    logic hit0;
    logic hit1;
    logic clr0;
    logic clr1;
    logic ce_rise;
    t = r.regs;
    c = 1'b0;
    hc = 9'h000;
    xt_rise = 1'b0;
    sec_tick = 1'b0;
    hit0 = 1'b0;
    hit1 = 1'b0;
    clr0 = 1'b0;
    clr1 = 1'b0;
    ce_rise = 1'b0;
    n = r;
    n.ce_s = {r.ce_s[1:0], ce};
    n.xt_s = {r.xt_s[1:0], crystal_in};
    n.md_s = {r.md_s[1:0], link_style_select};
    n.pa_s = {r.pa_s[1:0], primary_below_secondary};
    n.pb_s = {r.pb_s[1:0], primary_below_battery};
    n.tg_s = {r.tg_s[1:0], hr.tog};
    // a pin change counts only once stages two and three agree
    n.ce_f = settle(r.ce_s, r.ce_f);
    n.xt_f = settle(r.xt_s, r.xt_f);
    n.md_f = settle(r.md_s, r.md_f);
    n.pa_f = settle(r.pa_s, r.pa_f);
    n.pb_f = settle(r.pb_s, r.pb_f);
    xt_rise = (r.xt_s[1] == r.xt_s[2]) && r.xt_s[2] && !r.xt_f;
    if (xt_rise && !r.regs[A_CTRL][B_OSC]) begin
      if (r.presc == 15'(TICKS_PER_SEC - 1)) begin
        n.presc = 15'h0000;
        sec_tick = 1'b1;
      end else begin
        n.presc = r.presc + 15'h0001;
      end
    end
    // no supply gating: counting never depends on which source powers the core
    if (sec_tick) begin
      c = (t[A_SEC] == 8'h59);
      t[A_SEC] = c ? 8'h00 : bcd_inc(t[A_SEC]);
      if (c) begin
        c = (t[A_MIN] == 8'h59);
        t[A_MIN] = c ? 8'h00 : bcd_inc(t[A_MIN]);
      end
      if (c) begin
        hc = hour_inc(t[A_HOUR]);
        c = hc[8];
        t[A_HOUR] = hc[7:0];
      end
      if (c) begin
        t[A_DAY] = (t[A_DAY] == 8'h07) ? 8'h01 : bcd_inc(t[A_DAY]);
        c = (t[A_DATE] == month_end(t[A_MONTH], t[A_YEAR]));
        t[A_DATE] = c ? 8'h01 : bcd_inc(t[A_DATE]);
      end
      if (c) begin
        c = (t[A_MONTH] == 8'h12);
        t[A_MONTH] = c ? 8'h01 : bcd_inc(t[A_MONTH]);
      end
      if (c) begin
        t[A_YEAR] = (t[A_YEAR] == 8'h99) ? 8'h00 : bcd_inc(t[A_YEAR]);
      end
    end
    n.regs = t;
    // host write; a write to an alarm bank clears that bank's flag
    if (wr_clock) begin
      if (!wp) begin
        n.regs[hr.addr] = hr.data & write_mask(hr.addr);
        if (hr.addr == A_SEC) n.presc = 15'h0000;
        clr0 = in_bank(hr.addr, A_ALM0);
        clr1 = in_bank(hr.addr, A_ALM1);
      end else if (hr.addr == A_CTRL) begin
        n.regs[A_CTRL][B_WP] = hr.data[B_WP];
      end
    end
    if (clr0) n.regs[A_STAT][B_FLAG0] = 1'b0;
    if (clr1) n.regs[A_STAT][B_FLAG1] = 1'b0;
    // set after clear: an alarm landing with a clearing write is kept
    hit0 = sec_tick && alarm_hit(t, A_ALM0);
    hit1 = sec_tick && alarm_hit(t, A_ALM1);
    if (hit0) n.regs[A_STAT][B_FLAG0] = 1'b1;
    if (hit1) n.regs[A_STAT][B_FLAG1] = 1'b1;
    ce_rise = n.ce_f && !r.ce_f;
    if (ce_rise) n.snap = r.regs;
    n.irq_a = (r.regs[A_STAT][B_FLAG0] && r.regs[A_CTRL][B_EN0]) ||
              (!r.regs[A_CTRL][B_ROUTE] && r.regs[A_STAT][B_FLAG1] &&
               r.regs[A_CTRL][B_EN1]);
    n.irq_b = r.regs[A_CTRL][B_ROUTE] && r.regs[A_STAT][B_FLAG1] &&
              r.regs[A_CTRL][B_EN1];
    n.loss_n = !(r.pa_f || r.pb_f);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= CORE_RST;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_store) begin
      ram[hr.addr - A_RAM] <= hr.data;
    end
  end

  // ******************************************
  // link domain: address byte, then data bytes
  // ******************************************
  // spi shifts msb first, 3-wire lsb first
  assign byte_in = r.md_f ? {lr.sh[6:0], serial_in_pin} : {serial_in_pin, lr.sh[7:1]};
  assign byte_done = (lr.cnt == 3'h7);
  assign wr_fire = byte_done && lr.addr_done && lr.is_wr;

  always_comb begin
    ln = lr;
    ln.sh = byte_in;
    ln.cnt = lr.cnt + 3'h1;
    if (byte_done) begin
      if (!lr.addr_done) begin
        ln.addr = byte_in[6:0];
        ln.is_wr = byte_in[B_DIR];
        ln.addr_done = 1'b1;
      end else begin
        ln.addr = next_addr(lr.addr);
      end
    end
  end

  // chip enable low holds the link idle whatever sclk does
  always_ff @(posedge sclk or negedge ce) begin
    if (!ce) begin
      lr <= LINK_RST;
    end else begin
      lr <= ln;
    end
  end

  // held across the frame end so the core still sees the last byte
  always_ff @(posedge sclk or posedge srst) begin
    if (srst) begin
      hr <= HANDOFF_RST;
    end else if (wr_fire) begin
      hr <= '{tog: ~hr.tog, addr: lr.addr, data: byte_in};
    end
  end

  // frame snapshot and storage stay still while the link reads them
  always_comb begin
    if (lr.addr < A_RSVD) begin
      rd_byte = r.snap[lr.addr[4:0]];
    end else if (lr.addr < A_RAM) begin
      rd_byte = 8'h00;
    end else begin
      rd_byte = ram[lr.addr - A_RAM];
    end
    out_idx = r.md_f ? (3'h7 - lr.cnt) : lr.cnt;
  end

  always_ff @(negedge sclk or negedge ce) begin
    if (!ce) begin
      dr <= DRIVE_RST;
    end else begin
      dr <= '{obit: rd_byte[out_idx], drv: lr.addr_done && !lr.is_wr};
    end
  end

  // ******************************************
  // pins
  // ******************************************
  assign serial_out_pin = dr.obit;
  assign serial_out_oe_n = !(dr.drv && ce);
  assign alarm_irq_a_n = 1'b0;
  assign alarm_irq_a_oe_n = !r.irq_a;
  assign alarm_irq_b_n = 1'b0;
  assign alarm_irq_b_oe_n = !r.irq_b;
  assign supply_loss_n = r.loss_n;
endmodule : alarm_calendar_clock

/* host_link.sv */
// host model driving the serial link in spi or 3-wire style
`timescale 1ns/1ps
module host_link (
  output logic sclk,
  output logic ce,
  output logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe_n,
  input wire logic link_style_select
);
  logic hbit = 1'b0;
  logic host_oe = 1'b0;
  logic fill = 1'b0;
  logic rd_line;
  logic [7:0] rq[$];
  initial sclk = 1'b0;
  initial ce = 1'b0;
  // released lines show a moving pattern, never a held value
  always #16 fill = ~fill;
  assign rd_line = !serial_out_oe_n ? serial_out_pin : fill;
  assign serial_in_pin = host_oe ? hbit : (link_style_select ? fill : rd_line);
  task automatic put_byte(input logic [7:0] b, output logic [7:0] got);
    int k;
    for (int i = 0; i < 8; i++) begin
      k = link_style_select ? 7 - i : i;
      hbit = b[k];
      #16;
      sclk = 1'b1;
      got[k] = rd_line;
      #16;
      sclk = 1'b0;
    end
  endtask : put_byte
  task automatic xfer(input logic [7:0] a, input logic [7:0] q[$]);
    logic [7:0] got;
    // odd offset keeps link edges away from core edges
    #3;
    rq = {};
    ce = 1'b1;
    host_oe = 1'b1;
    #100;
    put_byte(a, got);
    host_oe = a[7];
    foreach (q[i]) begin
      put_byte(q[i], got);
      rq.push_back(got);
    end
    #160;
    ce = 1'b0;
    host_oe = 1'b0;
    #200;
  endtask : xfer
endmodule : host_link

/* rtc_pkg.sv */
// constants, register layout and state types of the serial alarm calendar clock
package rtc_pkg;
  // ******************************************
  // timing
  // ******************************************
  localparam int XTAL_HZ = 32768;
  // ******************************************
  // clock space indices (write address = index + 80h)
  // ******************************************
  localparam logic [6:0] A_SEC = 7'h00;
  localparam logic [6:0] A_MIN = 7'h01;
  localparam logic [6:0] A_HOUR = 7'h02;
  localparam logic [6:0] A_DAY = 7'h03;
  localparam logic [6:0] A_DATE = 7'h04;
  localparam logic [6:0] A_MONTH = 7'h05;
  localparam logic [6:0] A_YEAR = 7'h06;
  localparam logic [6:0] A_ALM0 = 7'h07;
  localparam logic [6:0] A_ALM1 = 7'h0B;
  localparam logic [6:0] A_CTRL = 7'h0F;
  localparam logic [6:0] A_STAT = 7'h10;
  localparam logic [6:0] A_RSVD = 7'h12;
  localparam logic [6:0] A_CLK_TOP = 7'h1F;
  localparam logic [6:0] A_RAM = 7'h20;
  localparam logic [6:0] A_RAM_TOP = 7'h7F;
  localparam int NREG = 18;
  localparam int RAM_BYTES = 96;
  // ******************************************
  // field positions
  // ******************************************
  localparam int B_DIR = 7;
  localparam int B_MASK = 7;
  localparam int B_OSC = 7;
  localparam int B_WP = 6;
  localparam int B_ROUTE = 2;
  localparam int B_EN1 = 1;
  localparam int B_EN0 = 0;
  localparam int B_H12 = 6;
  localparam int B_PM = 5;
  localparam int B_FLAG0 = 0;
  localparam int B_FLAG1 = 1;
  // ******************************************
  // writable bit masks, other bits stay zero
  // ******************************************
  localparam logic [7:0] M_TIME = 8'h7F;
  localparam logic [7:0] M_DAY = 8'h07;
  localparam logic [7:0] M_DATE = 8'h3F;
  localparam logic [7:0] M_MONTH = 8'h1F;
  localparam logic [7:0] M_YEAR = 8'hFF;
  localparam logic [7:0] M_ALM = 8'hFF;
  localparam logic [7:0] M_ALM_DAY = 8'h87;
  localparam logic [7:0] M_CTRL = 8'hC7;
  // ******************************************
  // state types
  // ******************************************
  typedef struct packed {
    logic [2:0] cnt;
    logic addr_done;
    logic is_wr;
    logic [7:0] sh;
    logic [6:0] addr;
  } link_t;
  typedef struct packed {
    logic tog;
    logic [6:0] addr;
    logic [7:0] data;
  } handoff_t;
  typedef struct packed {
    logic obit;
    logic drv;
  } drive_t;
  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic [NREG-1:0][7:0] snap;
    logic [14:0] presc;
    logic [2:0] ce_s;
    logic [2:0] xt_s;
    logic [2:0] md_s;
    logic [2:0] pa_s;
    logic [2:0] pb_s;
    logic [2:0] tg_s;
    logic ce_f;
    logic xt_f;
    logic md_f;
    logic pa_f;
    logic pb_f;
    logic irq_a;
    logic irq_b;
    logic loss_n;
  } core_t;
  localparam link_t LINK_RST = '0;
  localparam handoff_t HANDOFF_RST = '0;
  localparam drive_t DRIVE_RST = '0;
  localparam core_t CORE_RST = '{loss_n: 1'b1, default: '0};
endpackage : rtc_pkg

/* rtc_sva.sv */
// port checker of the alarm calendar clock
`timescale 1ns/1ps
module rtc_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic ce,
  input wire logic serial_in_pin,
  input wire logic serial_out_oe_n,
  input wire logic link_style_select,
  input wire logic primary_below_secondary,
  input wire logic primary_below_battery,
  input wire logic alarm_irq_a_n,
  input wire logic alarm_irq_a_oe_n,
  input wire logic alarm_irq_b_n,
  input wire logic supply_loss_n
);
  logic [3:0] bits_reg;
  logic wr_reg;
  logic low;
  assign low = primary_below_secondary | primary_below_battery;
  // ****
  // frame tracking, cleared by ce low just like the link
  // ****
  always_ff @(posedge sclk or negedge ce) begin
    if (!ce) begin
      bits_reg <= 4'h0;
      wr_reg <= 1'b0;
    end else begin
      if (bits_reg != 4'hF) bits_reg <= bits_reg + 4'h1;
      if (bits_reg == (link_style_select ? 4'h0 : 4'h7)) wr_reg <= serial_in_pin;
    end
  end
  // ****
  // assertions
  // ****
  chk_irq_a_open: assert property (@(posedge clk) disable iff (srst) !alarm_irq_a_n)
    else $error("irq a data high");
  chk_irq_b_open: assert property (@(posedge clk) disable iff (srst) !alarm_irq_b_n)
    else $error("irq b data high");
  chk_loss_low: assert property (@(posedge clk) disable iff (srst) low [*7] |-> !supply_loss_n)
    else $error("supply loss not shown");
  chk_loss_high: assert property (@(posedge clk) disable iff (srst) !low [*7] |-> supply_loss_n)
    else $error("supply loss false");
  chk_oe_idle: assert property (@(posedge clk) disable iff (srst) !ce |-> serial_out_oe_n)
    else $error("drive with ce low");
  chk_irq_hold: assert property (@(posedge clk) disable iff (srst)
    (!ce [*6]) ##0 !alarm_irq_a_oe_n |=> !alarm_irq_a_oe_n) else $error("irq a dropped");
  chk_addr_quiet: assert property (@(posedge sclk) disable iff (!ce)
    bits_reg < 4'h8 |-> serial_out_oe_n) else $error("drive in address");
  chk_wr_quiet: assert property (@(posedge sclk) disable iff (!ce)
    bits_reg >= 4'h8 && wr_reg |-> serial_out_oe_n) else $error("drive in write");
  chk_rd_drive: assert property (@(posedge sclk) disable iff (!ce)
    bits_reg >= 4'h8 && !wr_reg |-> !serial_out_oe_n) else $error("no drive in read");
endmodule : rtc_sva
bind alarm_calendar_clock rtc_sva i_rtc_sva (
  .clk(clk), .srst(srst), .sclk(sclk), .ce(ce), .serial_in_pin(serial_in_pin),
  .serial_out_oe_n(serial_out_oe_n), .link_style_select(link_style_select),
  .primary_below_secondary(primary_below_secondary),
  .primary_below_battery(primary_below_battery), .alarm_irq_a_n(alarm_irq_a_n),
  .alarm_irq_a_oe_n(alarm_irq_a_oe_n), .alarm_irq_b_n(alarm_irq_b_n),
  .supply_loss_n(supply_loss_n));

/* tb.sv */
// self-checking bench of the alarm calendar clock
`timescale 1ns/1ps
module tb;
  import rtc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic crystal_in = 1'b0;
  logic link_style_select = 1'b1;
  logic primary_below_secondary = 1'b0;
  logic primary_below_battery = 1'b0;
  logic sclk, ce, serial_in_pin, serial_out_pin, serial_out_oe_n, supply_loss_n;
  logic alarm_irq_a_n, alarm_irq_a_oe_n, alarm_irq_b_n, alarm_irq_b_oe_n;
  int errors = 0;
  int tests_run = 0;
  int f0 = 0;
  int f1 = 0;
  logic [7:0] ctl = 8'h00;
  logic [7:0] q[$];
  logic [7:0] e[8];
  logic [7:0] cv[6] = '{8'h05, 8'h06, 8'h07, 8'h01, 8'h02, 8'h03};
  logic [7:0] cal[5][8] = '{'{8'h23, 8'h28, 8'h02, 8'h00, 8'h00, 8'h29, 8'h02, 8'h00},
    '{8'h23, 8'h28, 8'h02, 8'h01, 8'h00, 8'h01, 8'h03, 8'h01},
    '{8'h23, 8'h30, 8'h04, 8'h23, 8'h00, 8'h01, 8'h05, 8'h23},
    '{8'h23, 8'h31, 8'h12, 8'h99, 8'h00, 8'h01, 8'h01, 8'h00},
    '{8'h71, 8'h15, 8'h06, 8'h24, 8'h52, 8'h16, 8'h06, 8'h24}};
  always #10 clk = ~clk;
  alarm_calendar_clock #(.TICKS_PER_SEC(4)) i_alarm_calendar_clock (.clk(clk), .srst(srst),
    .sclk(sclk), .ce(ce), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_oe_n(serial_out_oe_n), .link_style_select(link_style_select),
    .crystal_in(crystal_in), .primary_below_secondary(primary_below_secondary),
    .primary_below_battery(primary_below_battery), .alarm_irq_a_n(alarm_irq_a_n),
    .alarm_irq_a_oe_n(alarm_irq_a_oe_n), .alarm_irq_b_n(alarm_irq_b_n),
    .alarm_irq_b_oe_n(alarm_irq_b_oe_n), .supply_loss_n(supply_loss_n));
  host_link i_host_link (.sclk(sclk), .ce(ce), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
    .link_style_select(link_style_select));
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic test_done;
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [6:0] a, input logic [7:0] d[$]);
    @(posedge clk);
    i_host_link.xfer({1'b1, a}, d);
  endtask : wr
  task automatic rd(input string n, input logic [6:0] a, input logic [7:0] x[$]);
    @(posedge clk);
    i_host_link.xfer({1'b0, a}, x);
    foreach (x[i]) check(n, i_host_link.rq[i], x[i]);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      crystal_in <= 1'b1;
      repeat (4) @(posedge clk);
      crystal_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask : tick
  task automatic irq_chk;
    logic a;
    logic b;
    a = (f0 && ctl[B_EN0]) || (!ctl[B_ROUTE] && f1 && ctl[B_EN1]);
    b = ctl[B_ROUTE] && f1 && ctl[B_EN1];
    for (int i = 0; i < 20 && alarm_irq_a_oe_n !== !a; i++) @(posedge clk);
    check("irq_a", alarm_irq_a_oe_n, !a);
    check("irq_b", alarm_irq_b_oe_n, !b);
  endtask : irq_chk
  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(78));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (10) @(posedge clk);
    wr(A_CTRL, {8'h00});
    foreach (cal[r]) begin
      e = cal[r];
      wr(A_SEC, {8'h59, 8'h59, e[0], 8'hFF, e[1], e[2], e[3]});
      rd("day_mask", A_DAY, {8'h07});
      tick(4);
      rd("calendar", A_SEC, {8'h00, 8'h00, e[4], 8'h01, e[5], e[6], e[7]});
    end
    wr(A_CTRL, {8'h80});
    wr(A_SEC, {8'h10});
    tick(4);
    rd("osc_stop", A_SEC, {8'h10});
    wr(A_CTRL, {8'h00});
    tick(4);
    rd("osc_run", A_SEC, {8'h11});
    for (int i = 0; i < RAM_BYTES; i++) q.push_back(8'($urandom));
    wr(A_RAM, q);
    rd("ram", A_RAM, q);
    q = {8'($urandom), 8'($urandom), 8'($urandom)};
    wr(7'h7E, q);
    rd("ram_wrap", 7'h7E, q);
    wr(A_CTRL, {8'h40});
    wr(A_CTRL, {8'h47});
    wr(A_RAM, {~q[2]});
    rd("wp_ctrl", A_CTRL, {8'h40});
    rd("wp_ram", A_RAM, {q[2]});
    wr(A_CTRL, {8'h00});
    wr(A_RSVD, {8'hFF, 8'hFF});
    q = {};
    repeat (14) q.push_back(8'h00);
    rd("reserved", A_RSVD, q);
    link_style_select <= 1'b0;
    repeat (10) @(posedge clk);
    q = {8'($urandom), 8'hA5};
    wr(7'h40, q);
    rd("three_wire", 7'h40, q);
    link_style_select <= 1'b1;
    repeat (10) @(posedge clk);
    wr(A_ALM0, {8'h59, 8'h80, 8'h80, 8'h80});
    wr(A_ALM1, {8'h80, 8'h80, 8'h80, 8'h80});
    wr(A_SEC, {8'h58});
    tick(4);
    f0 = 1;
    f1 = 1;
    foreach (cv[i]) begin
      ctl = cv[i];
      wr(A_CTRL, {ctl});
      irq_chk();
    end
    rd("status", A_STAT, {8'h03});
    wr(A_ALM0, {8'h59});
    f0 = 0;
    irq_chk();
    wr(A_ALM1, {8'h80});
    f1 = 0;
    irq_chk();
    for (int i = 0; i < 4; i++) begin
      primary_below_secondary <= i[0];
      primary_below_battery <= i[1];
      repeat (10) @(posedge clk);
      check("loss", supply_loss_n, !(i[0] | i[1]));
    end
    wr(A_SEC, {8'h30});
    tick(4);
    rd("backup_run", A_SEC, {8'h31});
    test_done();
  end
  // hang guard, well inside the cycle budget
  initial begin
    #1500000;
    errors++;
    test_done();
  end
endmodule : tb
